/* hw/serial_flash_status_write_gate.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Modes 0 and 3, set by idle clock
// - Sample on rising, launch on falling edge
// - Line 0 in, line 1 out single; lines 0-3 quad
// - Uniform 4 KB sectors, 32/64 KB blocks
// - 24-bit address, top 7FFFFFh, 2048 sectors
// - Register read repeats until chip select rises
// - Status bits: busy, latch, protect, quad, lock
// - Persistent bits written only by status write
// - Status write data leaves the latch alone
// - Busy set during operation, cleared after
// - While busy ignore all but reads, reset
// - Latch set/cleared by commands; gates writes
// - Volatile parameter sets need no latch
// - Latch clears when an operation completes
// - Gated: 02h, 32h/38h, D7h/20h
// - Gated: 52h, D8h, C7h/60h
// - Gated: 01h, 42h, 65h, 15h
// - Gated: 85h, 64h, 62h
// - Quad program and quad mode entry only with quad enable
// - Lock with protect pin low, quad off, blocks status writes
// - Array erase needs all protect bits zero
module serial_flash_status_write_gate (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        data_line_0_in,
   output var  logic        data_line_0_out,
   output var  logic        data_line_0_oe_n,
   input  wire logic        data_line_1_in,
   output var  logic        data_line_1_out,
   output var  logic        data_line_1_oe_n,
   input  wire logic        data_line_2_in,
   output var  logic        data_line_2_out,
   output var  logic        data_line_2_oe_n,
   input  wire logic        data_line_3_in,
   output var  logic        data_line_3_out,
   output var  logic        data_line_3_oe_n,
   output var  logic        idle_clock_high,
   output var  logic        quad_command_mode,
   output var  logic [7:0]  flash_status,
   output var  logic [10:0] op_sector,
   output var  logic [7:0]  op_half_block,
   output var  logic [6:0]  op_block
);
   // ==========================================================
   // Decoding helpers
   // Opcodes that need the write-enable latch
   function automatic logic is_gated(input logic [7:0] op);
      case (op)
         serial_flash_pkg::OP_PAGE_PROGRAM,
         serial_flash_pkg::OP_QUAD_PROGRAM_A,
         serial_flash_pkg::OP_QUAD_PROGRAM_B,
         serial_flash_pkg::OP_SECTOR_ERASE_A,
         serial_flash_pkg::OP_SECTOR_ERASE_B:     is_gated = 1'b1;
         serial_flash_pkg::OP_HALF_BLOCK_ERASE,
         serial_flash_pkg::OP_FULL_BLOCK_ERASE,
         serial_flash_pkg::OP_ARRAY_ERASE_A,
         serial_flash_pkg::OP_ARRAY_ERASE_B:      is_gated = 1'b1;
         serial_flash_pkg::OP_STATUS_WRITE,
         serial_flash_pkg::OP_FUNCTION_WRITE,
         serial_flash_pkg::OP_READ_PARAM_NV,
         serial_flash_pkg::OP_BOOT_CONFIG_WRITE:  is_gated = 1'b1;
         serial_flash_pkg::OP_EXT_READ_PARAM_NV,
         serial_flash_pkg::OP_INFO_ROW_ERASE,
         serial_flash_pkg::OP_INFO_ROW_PROGRAM:   is_gated = 1'b1;
         default:                                 is_gated = 1'b0;
      endcase
   endfunction : is_gated

   // Opcodes that carry a three-byte address
   function automatic logic has_address(input logic [7:0] op);
      has_address = is_gated(op) && (op != serial_flash_pkg::OP_STATUS_WRITE)
                    && (op != serial_flash_pkg::OP_FUNCTION_WRITE)
                    && (op != serial_flash_pkg::OP_READ_PARAM_NV)
                    && (op != serial_flash_pkg::OP_BOOT_CONFIG_WRITE)
                    && (op != serial_flash_pkg::OP_EXT_READ_PARAM_NV)
                    && (op != serial_flash_pkg::OP_ARRAY_ERASE_A)
                    && (op != serial_flash_pkg::OP_ARRAY_ERASE_B);
   endfunction : has_address

   // ==========================================================
   // Link side state (sck domain)
   logic       frame_fresh;      // Set outside frames, cleared by first rise
   logic [2:0] bit_cnt;          // Bit position within the current byte
   logic [2:0] byte_cnt;         // Bytes received in this frame
   logic [7:0] shift;            // Receive shift register
   logic [7:0] opcode;           // First byte of the frame
   logic [7:0] wr_data;          // Second byte, used by status write
   logic [23:0] addr;            // Three address bytes
   logic       got_op;           // Opcode complete
   logic       got_data;         // Status write byte complete
   logic       got_addr;         // Address complete
   logic [7:0] snap;             // Status captured at select fall
   logic       wide_frame;       // Frame runs four lines wide
   logic [2:0] tx_pos;           // Output bit position
   logic [2:0] step;             // Bits per clock
   logic [7:0] next_shift;       // Shift value after this rise
   logic       byte_done;        // This rise completes a byte
   logic [2:0] cnt_now;          // Byte count seen at this rise

   // ==========================================================
   // Core side state (mclk domain)
   serial_flash_pkg::exec_state_type state;
   logic [2:0] cs_sync;          // Select synchroniser, three stages
   logic       cs_level;         // Filtered select level
   logic [2:0] wp_sync;          // Protect pin synchroniser
   logic       wp_level;         // Filtered protect pin level
   logic       frame_end;        // One cycle at each select rise
   logic       busy_flag;
   logic       write_enable_latch;
   logic [3:0] block_protect;    // block_protect_bit3..block_protect_bit0
   logic       quad_io_enable;
   logic       status_write_lock;
   logic       reset_armed;      // Reset enable seen in the last frame
   logic       pend_status;      // Status write waiting for completion
   logic [7:0] pend_value;       // Value that the status write will store
   logic [15:0] timer;           // Remaining cycles of the operation
   logic       locked;           // Status register currently read-only
   logic       may_start;        // Gated command accepted this frame

   // ==========================================================
   // Mode pick and status snapshot at select fall
   // Both values are stable in the core when a frame opens
   always_ff @(negedge cs_n)
   begin
      idle_clock_high <= sck;
      snap            <= flash_status;
      wide_frame      <= quad_command_mode;
   end

   // ==========================================================
   // Receive datapath
   assign step      = wide_frame ? serial_flash_pkg::STEP_QUAD : serial_flash_pkg::STEP_SINGLE;
   assign byte_done = (bit_cnt == (3'h0 - step));
   assign cnt_now   = frame_fresh ? 3'h0 : byte_cnt;
   // Wide frames take four lines per clock, narrow frames one
   always_comb
   begin
      if (wide_frame)
      begin
         next_shift = {shift[3:0], data_line_3_in, data_line_2_in,
                       data_line_1_in, data_line_0_in};
      end
      else
      begin
         next_shift = {shift[6:0], data_line_0_in};
      end
   end

   // Bit counter, restarted by the frame's own select
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         bit_cnt     <= 3'h0;
         frame_fresh <= 1'b1;
      end
      else
      begin
         bit_cnt     <= bit_cnt + step;
         frame_fresh <= 1'b0;
      end
   end

   // Byte capture on the rising edge; results outlive the frame
   always_ff @(posedge sck)
   begin
      shift <= next_shift;
      if (frame_fresh)
      begin
         byte_cnt <= 3'h0;
         got_op   <= 1'b0;
         got_data <= 1'b0;
         got_addr <= 1'b0;
      end
      if (byte_done && (cnt_now != serial_flash_pkg::BYTES_FULL))
      begin
         byte_cnt <= cnt_now + 3'h1;
         case (cnt_now)
            3'h0:
            begin
               opcode <= next_shift;
               got_op <= 1'b1;
            end
            3'h1:
            begin
               wr_data      <= next_shift;
               got_data     <= 1'b1;
               addr[23:16]  <= next_shift;
            end
            3'h2:    addr[15:8] <= next_shift;
            3'h3:
            begin
               addr[7:0] <= next_shift;
               got_addr  <= 1'b1;
            end
            default: addr[7:0] <= addr[7:0];
         endcase
      end
   end

   // ==========================================================
   // Transmit datapath: status read repeats the snapshot
   always_ff @(negedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         tx_pos           <= 3'h0;
         data_line_0_out  <= 1'b0;
         data_line_1_out  <= 1'b0;
         data_line_2_out  <= 1'b0;
         data_line_3_out  <= 1'b0;
         data_line_0_oe_n <= 1'b1;
         data_line_1_oe_n <= 1'b1;
         data_line_2_oe_n <= 1'b1;
         data_line_3_oe_n <= 1'b1;
      end
      else if (!frame_fresh && got_op && (opcode == serial_flash_pkg::OP_STATUS_READ))
      begin
         // Launch on the falling edge, wrap to repeat the byte
         tx_pos <= tx_pos + step;
         if (wide_frame)
         begin
            {data_line_3_out, data_line_2_out, data_line_1_out, data_line_0_out}
               <= tx_pos[2] ? snap[3:0] : snap[7:4];
            data_line_0_oe_n <= 1'b0;
            data_line_1_oe_n <= 1'b0;
            data_line_2_oe_n <= 1'b0;
            data_line_3_oe_n <= 1'b0;
         end
         else
         begin
            data_line_1_out  <= snap[3'h7 - tx_pos];
            data_line_1_oe_n <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Synchronisers into the core clock
   // Select and protect pin pass three stages; second and third must agree
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cs_sync  <= 3'h7;
         cs_level <= 1'b1;
         wp_sync  <= 3'h7;
         wp_level <= 1'b1;
      end
      else
      begin
         cs_sync <= {cs_sync[1:0], cs_n};
         wp_sync <= {wp_sync[1:0], data_line_2_in};
         if (cs_sync[1] == cs_sync[2])
         begin
            cs_level <= cs_sync[2];
         end
         if (wp_sync[1] == wp_sync[2])
         begin
            wp_level <= wp_sync[2];
         end
      end
   end
   assign frame_end = !cs_level && cs_sync[1] && cs_sync[2];

   // ==========================================================
   // Command gating
   // Protect pin is only a pin while quad is off
   assign locked    = status_write_lock && !quad_io_enable && !wp_level;
   always_comb
   begin
      may_start = 1'b0;
      if (got_op && is_gated(opcode) && write_enable_latch)
      begin
         may_start = 1'b1;
         if (opcode == serial_flash_pkg::OP_STATUS_WRITE)
         begin
            may_start = got_data && !locked;
         end
         else if ((opcode == serial_flash_pkg::OP_ARRAY_ERASE_A) ||
                  (opcode == serial_flash_pkg::OP_ARRAY_ERASE_B))
         begin
            may_start = (block_protect == 4'h0);
         end
         else if ((opcode == serial_flash_pkg::OP_QUAD_PROGRAM_A) ||
                  (opcode == serial_flash_pkg::OP_QUAD_PROGRAM_B))
         begin
            may_start = quad_io_enable && got_addr;
         end
         else if (has_address(opcode))
         begin
            may_start = got_addr;
         end
      end
   end

   // ==========================================================
   // Executor: acts once per frame end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state              <= serial_flash_pkg::EXEC_IDLE;
         busy_flag          <= 1'b0;
         write_enable_latch <= 1'b0;
         quad_command_mode  <= 1'b0;
         reset_armed        <= 1'b0;
         pend_status        <= 1'b0;
         pend_value         <= serial_flash_pkg::STATUS_RESET;
         timer              <= 16'h0000;
      end
      else if (frame_end && got_op && reset_armed &&
               (opcode == serial_flash_pkg::OP_RESET))
      begin
         // Software reset is honoured even while busy
         state              <= serial_flash_pkg::EXEC_IDLE;
         busy_flag          <= 1'b0;
         write_enable_latch <= 1'b0;
         quad_command_mode  <= 1'b0;
         reset_armed        <= 1'b0;
         pend_status        <= 1'b0;
      end
      else if (state == serial_flash_pkg::EXEC_BUSY)
      begin
         if (frame_end)
         begin
            reset_armed <= got_op && (opcode == serial_flash_pkg::OP_RESET_ENABLE);
         end
         // Everything else is ignored until the timer runs out
         if (timer == 16'h0000)
         begin
            state              <= serial_flash_pkg::EXEC_IDLE;
            busy_flag          <= 1'b0;
            write_enable_latch <= 1'b0;
            pend_status        <= 1'b0;
         end
         else
         begin
            timer <= timer - 16'h0001;
         end
      end
      else if (frame_end && got_op)
      begin
         reset_armed <= (opcode == serial_flash_pkg::OP_RESET_ENABLE);
         case (opcode)
            serial_flash_pkg::OP_WRITE_ENABLE:  write_enable_latch <= 1'b1;
            serial_flash_pkg::OP_WRITE_DISABLE: write_enable_latch <= 1'b0;
            serial_flash_pkg::OP_ENTER_QUAD_CMD:
               quad_command_mode <= quad_io_enable;
            serial_flash_pkg::OP_EXIT_QUAD_CMD: quad_command_mode <= 1'b0;
            // Volatile sets hold no state here and need no latch
            serial_flash_pkg::OP_READ_PARAM_VOL,
            serial_flash_pkg::OP_EXT_READ_PARAM_VOL:
               write_enable_latch <= write_enable_latch;
            default:
            begin
               if (may_start)
               begin
                  state       <= serial_flash_pkg::EXEC_BUSY;
                  busy_flag   <= 1'b1;
                  timer       <= 16'(serial_flash_pkg::OP_CYCLES - 1);
                  pend_status <= (opcode == serial_flash_pkg::OP_STATUS_WRITE);
                  pend_value  <= wr_data;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Persistent status bits: written only at status write completion
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         block_protect     <= serial_flash_pkg::STATUS_RESET[serial_flash_pkg::BIT_BP_LO +: 4];
         quad_io_enable    <= serial_flash_pkg::STATUS_RESET[serial_flash_pkg::BIT_QUAD_EN];
         status_write_lock <= serial_flash_pkg::STATUS_RESET[serial_flash_pkg::BIT_LOCK];
      end
      else if ((state == serial_flash_pkg::EXEC_BUSY) && pend_status && (timer == 16'h0000))
      begin
         // Latch and busy bits of the written byte are dropped
         block_protect     <= pend_value[serial_flash_pkg::BIT_BP_LO +: 4];
         quad_io_enable    <= pend_value[serial_flash_pkg::BIT_QUAD_EN];
         status_write_lock <= pend_value[serial_flash_pkg::BIT_LOCK];
      end
   end

   // Status byte as read out
   assign flash_status = {status_write_lock, quad_io_enable, block_protect,
                          write_enable_latch, busy_flag};

   // ==========================================================
   // Address decode of the accepted operation
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         op_sector     <= 11'h000;
         op_half_block <= 8'h00;
         op_block      <= 7'h00;
      end
      else if (frame_end && (state == serial_flash_pkg::EXEC_IDLE) && may_start)
      begin
         op_sector     <= addr[serial_flash_pkg::SECTOR_LSB +:
                               serial_flash_pkg::SECTOR_BITS];
         op_half_block <= addr[serial_flash_pkg::HALF_BLOCK_LSB +: serial_flash_pkg::HALF_BITS];
         op_block      <= addr[serial_flash_pkg::BLOCK_LSB +: serial_flash_pkg::BLOCK_BITS];
      end
   end

   // ==========================================================
   // Checks
   localparam int BUSY_MAX = serial_flash_pkg::OP_CYCLES + 2;

   chk_busy_bounded: assert property (@(posedge mclk) disable iff (rst)
      $rose(busy_flag) |-> ##[1:BUSY_MAX] !busy_flag)
      else $error("busy flag held too long");
   chk_latch_done_clear: assert property (@(posedge mclk) disable iff (rst)
      $fell(busy_flag) |-> !write_enable_latch)
      else $error("latch not cleared at completion");
   chk_start_needs_latch: assert property (@(posedge mclk) disable iff (rst)
      $rose(busy_flag) |-> $past(write_enable_latch) && $past(frame_end))
      else $error("operation started without latch");
   chk_busy_ignores_cmd: assert property (@(posedge mclk) disable iff (rst)
      (busy_flag && frame_end && got_op && (timer > 16'h0001) &&
       (opcode == serial_flash_pkg::OP_WRITE_DISABLE)) |=> write_enable_latch)
      else $error("command taken while busy");
   chk_enable_sets: assert property (@(posedge mclk) disable iff (rst)
      (!busy_flag && frame_end && got_op &&
       (opcode == serial_flash_pkg::OP_WRITE_ENABLE)) |=> write_enable_latch)
      else $error("write enable not taken");
   chk_persist_source: assert property (@(posedge mclk) disable iff (rst)
      $changed(flash_status[7:2]) |-> $past(pend_status) && $fell(busy_flag))
      else $error("persistent bits changed outside status write");
   chk_lock_blocks: assert property (@(posedge mclk) disable iff (rst)
      (!busy_flag && frame_end && got_op && locked &&
       (opcode == serial_flash_pkg::OP_STATUS_WRITE)) |=> !busy_flag)
      else $error("locked status write accepted");
   chk_array_erase_guard: assert property (@(posedge mclk) disable iff (rst)
      (!busy_flag && frame_end && got_op && (block_protect != 4'h0) &&
       (opcode == serial_flash_pkg::OP_ARRAY_ERASE_A)) |=> !busy_flag)
      else $error("array erase ran with protection set");
   chk_quad_mode_qe: assert property (@(posedge mclk) disable iff (rst)
      $rose(quad_command_mode) |-> $past(quad_io_enable))
      else $error("quad mode entered without quad enable");
endmodule : serial_flash_status_write_gate
`default_nettype wire

/* hw/serial_flash_pkg.sv */
`default_nettype none
package serial_flash_pkg;
   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_WRITE_ENABLE       = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE      = 8'h04;
   localparam logic [7:0] OP_STATUS_READ        = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE       = 8'h01;
   localparam logic [7:0] OP_PAGE_PROGRAM       = 8'h02;
   localparam logic [7:0] OP_QUAD_PROGRAM_A     = 8'h32;
   localparam logic [7:0] OP_QUAD_PROGRAM_B     = 8'h38;
   localparam logic [7:0] OP_SECTOR_ERASE_A     = 8'hd7;
   localparam logic [7:0] OP_SECTOR_ERASE_B     = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE   = 8'h52;
   localparam logic [7:0] OP_FULL_BLOCK_ERASE   = 8'hd8;
   localparam logic [7:0] OP_ARRAY_ERASE_A      = 8'hc7;
   localparam logic [7:0] OP_ARRAY_ERASE_B      = 8'h60;
   localparam logic [7:0] OP_FUNCTION_WRITE     = 8'h42;
   localparam logic [7:0] OP_READ_PARAM_NV      = 8'h65;
   localparam logic [7:0] OP_BOOT_CONFIG_WRITE  = 8'h15;
   localparam logic [7:0] OP_EXT_READ_PARAM_NV  = 8'h85;
   localparam logic [7:0] OP_INFO_ROW_ERASE     = 8'h64;
   localparam logic [7:0] OP_INFO_ROW_PROGRAM   = 8'h62;
   localparam logic [7:0] OP_READ_PARAM_VOL     = 8'hc0;
   localparam logic [7:0] OP_EXT_READ_PARAM_VOL = 8'h83;
   localparam logic [7:0] OP_ENTER_QUAD_CMD     = 8'h35;
   localparam logic [7:0] OP_EXIT_QUAD_CMD      = 8'hf5;
   localparam logic [7:0] OP_RESET_ENABLE       = 8'h66;
   localparam logic [7:0] OP_RESET              = 8'h99;
   // ==========================================================
   // Status register layout
   localparam int          BIT_BUSY     = 0;
   localparam int          BIT_LATCH    = 1;
   localparam int          BIT_BP_LO    = 2;
   localparam int          BIT_QUAD_EN  = 6;
   localparam int          BIT_LOCK     = 7;
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   // ==========================================================
   // Address map: 4 KB sectors, 32 KB and 64 KB blocks
   localparam logic [23:0] ADDR_TOP       = 24'h7fffff;
   localparam int          SECTOR_LSB     = 12;
   localparam int          SECTOR_BITS    = 11;
   localparam int          HALF_BLOCK_LSB = 15;
   localparam int          HALF_BITS      = 8;
   localparam int          BLOCK_LSB      = 16;
   localparam int          BLOCK_BITS     = 7;
   // ==========================================================
   // Link framing
   localparam logic [2:0]  STEP_SINGLE = 3'h1;
   localparam logic [2:0]  STEP_QUAD   = 3'h4;
   localparam logic [2:0]  BYTES_FULL  = 3'h4;
   // ==========================================================
   // Timing of an internal write operation
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          OP_TIME_NS    = 2000;
   localparam int          OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Execution states
   typedef enum logic [1:0] {
      EXEC_IDLE = 2'b00,
      EXEC_BUSY = 2'b01
   } exec_state_type;
endpackage : serial_flash_pkg
`default_nettype wire

/* dv/spi_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Link master: one frame per call, idle clock level picks mode
module spi_master_model (
   output var  logic sck,
   output var  logic cs_n,
   output var  logic mosi,
   input  wire logic miso
);
   // Idle: deselected, clock parked low
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Shift n bytes MSB first; keep the last 16 bits seen on miso
   task automatic xfer(input logic [31:0] tx, input int n, input logic mode3,
                       output logic [15:0] rx);
      rx = 16'h0000;
      sck = mode3;
      #60 cs_n = 1'b0;
      #20; // Idle clock level stands past the select fall
      for (int i = 0; i < n * 8; i++)
      begin
         sck = 1'b0;
         mosi = tx[31 - i];
         #62.5 sck = 1'b1;
         rx = {rx[14:0], miso};
         #62.5;
      end
      sck = mode3;
      #60 cs_n = 1'b1;
      mosi = ~mosi;
      #400; // Deselect gap between frames
   endtask : xfer
endmodule : spi_master_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("Error %0t: got %h", $time, (a)); end end
module testbench;
   // ==========================================
   // Bench signals
   logic        mclk;
   logic        rst = 1'b1;
   logic        sck;
   logic        cs_n;
   logic        mosi;
   logic        l1_out;
   logic        l1_oe_n;
   logic [7:0]  st;
   wire  logic [25:0] area;
   logic [15:0] rx;
   logic        idle_hi;
   logic        quad_cmd;
   logic        protect_n = 1'b1;
   int          failures = 0;
   int          checks_done = 0;
   // Line 1 level: released line shows the inverse of its last drive
   wire  logic  line1 = l1_oe_n ? ~l1_out : l1_out;
   // Core clock, 40 ns
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   spi_master_model spi_master_model_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(line1));
   serial_flash_status_write_gate serial_flash_status_write_gate_inst (
      .mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n), .data_line_0_in(mosi),
      .data_line_0_out(), .data_line_0_oe_n(), .data_line_1_in(line1),
      .data_line_1_out(l1_out), .data_line_1_oe_n(l1_oe_n), .data_line_2_in(protect_n),
      .data_line_2_out(), .data_line_2_oe_n(), .data_line_3_in(1'b1), .data_line_3_out(),
      .data_line_3_oe_n(), .idle_clock_high(idle_hi), .quad_command_mode(quad_cmd),
      .flash_status(st),
      .op_sector(area[10:0]), .op_half_block(area[18:11]), .op_block(area[25:19]));
   // ==========================================
   // Verdict and end of run
   task wrap_up;
      $display("failures=%0d checks_done=%0d", failures, checks_done);
      if (failures == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // Bounded wait for the busy flag to drop
   task wait_idle;
      for (int k = 0; k < 100 && st[0] !== 1'b0; k++)
         @(negedge mclk);
      if (st[0] !== 1'b0)
      begin
         failures++;
         wrap_up();
      end
   endtask : wait_idle
   // Every gated opcode is dropped while the latch is clear
   task t_refused;
      static logic [7:0] ops [16] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7,
                               8'h60, 8'h01, 8'h42, 8'h65, 8'h15, 8'h85, 8'h64, 8'h62};
      foreach (ops[i])
      begin
         spi_master_model_inst.xfer({ops[i], 24'h001000}, 4, 1'b0, rx);
         `CHK(st, 8'h00)
      end
   endtask : t_refused
   // Latch set then cleared by its two commands
   task t_latch;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b1, rx);
      `CHK(st, 8'h02)
      `CHK(idle_hi, 1'b1)
      spi_master_model_inst.xfer(32'h32001000, 4, 1'b0, rx);
      `CHK(st, 8'h02)
      spi_master_model_inst.xfer(32'h35000000, 1, 1'b0, rx);
      `CHK(quad_cmd, 1'b0)
      spi_master_model_inst.xfer(32'h04000000, 1, 1'b0, rx);
      `CHK(st, 8'h00)
      `CHK(idle_hi, 1'b0)
   endtask : t_latch
   // Status write, reads while busy and after, repeated register value
   task t_status_write;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b0, rx);
      spi_master_model_inst.xfer(32'h013e0000, 2, 1'b0, rx);
      `CHK(st[0], 1'b1)
      spi_master_model_inst.xfer(32'h05000000, 3, 1'b1, rx);
      `CHK(rx, 16'h0303)
      wait_idle();
      `CHK(st, 8'h3c)
      spi_master_model_inst.xfer(32'h05000000, 3, 1'b0, rx);
      `CHK(rx, 16'h3c3c)
   endtask : t_status_write
   // Array erase refused with protect bits set, then bits cleared
   task t_protect;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b0, rx);
      spi_master_model_inst.xfer(32'hc7000000, 1, 1'b0, rx);
      `CHK(st, 8'h3e)
      spi_master_model_inst.xfer(32'h01000000, 2, 1'b0, rx);
      wait_idle();
      `CHK(st, 8'h00)
   endtask : t_protect
   // Lock bit with the protect pin low refuses a status write
   task t_lock;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b0, rx);
      spi_master_model_inst.xfer(32'h01800000, 2, 1'b0, rx);
      wait_idle();
      `CHK(st, 8'h80)
      @(posedge mclk);
      #1 protect_n = 1'b0;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b0, rx);
      spi_master_model_inst.xfer(32'h01000000, 2, 1'b0, rx);
      `CHK(st, 8'h82)
      @(posedge mclk);
      #1 protect_n = 1'b1;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b0, rx);
      spi_master_model_inst.xfer(32'h01000000, 2, 1'b0, rx);
      wait_idle();
      `CHK(st, 8'h00)
   endtask : t_lock
   // Sector erase at the top of the map
   task t_erase_map;
      spi_master_model_inst.xfer(32'h06000000, 1, 1'b0, rx);
      spi_master_model_inst.xfer(32'h207ff123, 4, 1'b0, rx);
      `CHK(st[0], 1'b1)
      spi_master_model_inst.xfer(32'h04000000, 1, 1'b0, rx);
      wait_idle();
      `CHK(area, {7'h7f, 8'hff, 11'h7ff})
      `CHK(st, 8'h00)
   endtask : t_erase_map
   // Main sequence
   initial
   begin
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (4) @(posedge mclk);
      `CHK(st, 8'h00)
      t_refused();
      t_latch();
      t_status_write();
      t_protect();
      t_lock();
      t_erase_map();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
